// ==== verilog/serial_host_port_regs.svh ====
/*
 Constants of the serial host port: buffer depths, word width, reset values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef SERIAL_HOST_PORT_REGS_SVH
`define SERIAL_HOST_PORT_REGS_SVH
`define SHP_WORD_W 24
`define SHP_RX_DEPTH 10
`define SHP_TX_DEPTH 4
`define SHP_SYNC_RST 4'hF
`define SHP_PRV_RST 2'h3
`define SHP_DIV_RST 8'h00
`define SHP_SH_RST 24'h000000
`endif

// ==== verilog/serial_host_port_pkg.sv ====
/*
 Types of the serial host port: configuration and interrupt carriers, states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_host_port_pkg;
   typedef struct packed {
      logic i2c_mode;
      logic master_select_bit;
      logic [1:0] word_bytes;
      logic [7:0] clk_div;
      logic [6:0] own_addr;
      logic master_read;
   } cfg_s;
   typedef struct packed {
      logic rx;
      logic tx;
      logic rx_exc;
      logic bus_err;
   } irq_s;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_START = 7'h02,
      ST_SPI = 7'h04,
      ST_ADDR = 7'h08,
      ST_DATA = 7'h10,
      ST_ACK = 7'h20,
      ST_STOP = 7'h40
   } state_e;
endpackage : serial_host_port_pkg

// ==== verilog/serial_host_port.sv ====
/*
 Serial host port: SPI or I2C engine, slave or single master, with a
 4-word transmit FIFO and a 10-word receive FIFO toward the core.
 Assumes core-side ports are synchronous to ref_clk; bus pins are resolved
 outside from the output enables and are synchronised here.
*/
// Notes on behaviour
// R01 - Runs SPI or I2C as selected, as slave or single master.
// R02 - Words are one, two or three bytes in both protocols.
// R03 - Received words queue in a ten-entry receive FIFO.
// R04 - SPI shifts data out and in together on each clock.
// R05 - SPI slave takes part only while selected.
// R06 - Separate receive and transmit interrupt requests with status.
// R07 - Receive exception raises its own request.
// R08 - Bus error raises its own request.
// R09 - Master mode makes the bus clock with a programmable divider.
// R10 - Slave mode disables the generator; clock comes from the bus.
// R11 - I2C detects start and stop; master generates them.
// R12 - I2C slave answers only to its own address.
// R13 - I2C direction comes from the address byte.
// R14 - I2C data moves byte by byte, timed by SCL.
// R15 - I2C drives acknowledge after each received byte except the last byte of a master read.
// R16 - I2C samples acknowledge after each transmitted byte.
// R17 - Registers are core-mapped locations, here core-side ports.
// R18 - Far party reaches the port only through the shift register.
// R19 - Slave clock and data are synchronised before use.
`timescale 1ns/1ps
`include "serial_host_port_regs.svh"

module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wp_r, rp_r;
   logic [CW-1:0] cnt_r;
   logic wr, rd;
   assign wr = in_valid & in_ready;
   assign rd = out_valid & out_ready;
   assign in_ready = cnt_r != CW'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rp_r];
   // Storage needs no reset; count guards every read
   always_ff @(posedge ref_clk) begin
      if (wr) begin
         mem[wp_r] <= in_data;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (wr) begin
            wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'h1;
         end
         if (rd) begin
            rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'h1;
         end
         if (wr && !rd) begin
            cnt_r <= cnt_r + 1'h1;
         end else if (rd && !wr) begin
            cnt_r <= cnt_r - 1'h1;
         end
      end
   end
endmodule : word_fifo

module serial_host_port (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire serial_host_port_pkg::cfg_s cfg,
   input wire logic [23:0] tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [23:0] rx_word,
   output logic rx_valid,
   input wire logic rx_ready,
   output serial_host_port_pkg::irq_s irq,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic sdi,
   input wire logic sel_in_n,
   output logic sel_out_n
);
   logic [3:0] sy1_r, sy2_r;
   logic [1:0] prv_r;
   serial_host_port_pkg::state_e state_r;
   logic [7:0] div_r;
   logic [23:0] sh_r, ld, rx_next, tq_word;
   logic [4:0] bitc_r, nbits;
   logic [1:0] bytec_r, nbytes;
   logic sck_r, ackph_r, dir_r, txb_r, sda_low_r, dout_r, last_r, nack_r, wdone_r;
   logic i2c, mst, s_sck, s_sda, s_sdi, s_sel_n, start_det, stop_det;
   logic run, tick, rise, fall, din, dev_tx, spi_go, spi_end, i2c_end;
   logic addr_done, ack_exit, to_data, arb_lost, err_ev, pop, push;
   logic tq_valid, rq_ready;
   logic [7:0] addr_byte;

   function automatic logic [23:0] justify(input logic [23:0] w, input logic [1:0] n);
      case (n)
         2'h1: justify = {w[7:0], 16'h0000};
         2'h2: justify = {w[15:0], 8'h00};
         default: justify = w;
      endcase
   endfunction : justify

   function automatic logic [23:0] keep(input logic [23:0] w, input logic [1:0] n);
      case (n)
         2'h1: keep = {16'h0000, w[7:0]};
         2'h2: keep = {8'h00, w[15:0]};
         default: keep = w;
      endcase
   endfunction : keep

   // Bus pins pass two flops; edges are seen only past the second
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sy1_r <= `SHP_SYNC_RST;
         sy2_r <= `SHP_SYNC_RST;
         prv_r <= `SHP_PRV_RST;
      end else begin
         sy1_r <= {sel_in_n, sdi, sda_i, sck_i}; // [R19]
         sy2_r <= sy1_r;
         prv_r <= sy2_r[1:0];
      end
   end
   assign s_sck = sy2_r[0];
   assign s_sda = sy2_r[1];
   assign s_sdi = sy2_r[2];
   assign s_sel_n = sy2_r[3];
   assign start_det = s_sck & prv_r[0] & prv_r[1] & !s_sda; // [R11]
   assign stop_det = s_sck & prv_r[0] & !prv_r[1] & s_sda; // [R11]

   assign i2c = cfg.i2c_mode; // [R01]
   assign mst = cfg.master_select_bit; // [R01] [R17]
   assign nbytes = (cfg.word_bytes == 2'h0) ? 2'h1 : cfg.word_bytes; // [R02]
   assign nbits = {nbytes, 3'h0};
   assign run = mst & (state_r != serial_host_port_pkg::ST_IDLE);
   assign tick = run & (div_r == cfg.clk_div); // [R09]
   // Slave edges come from the synchronised pin, master edges from the divider
   assign rise = mst ? (tick & !sck_r) : (s_sck & !prv_r[0]); // [R10] [R19]
   assign fall = mst ? (tick & sck_r & (state_r != serial_host_port_pkg::ST_STOP))
                     : (!s_sck & prv_r[0]);
   assign din = i2c ? s_sda : s_sdi;
   assign dev_tx = mst ? !cfg.master_read : dir_r; // [R13]
   assign ld = justify(tq_valid ? tq_word : 24'h000000, nbytes); // [R02]
   assign rx_next = {sh_r[22:0], din};
   assign addr_byte = rx_next[7:0];
   assign spi_go = !i2c & (state_r == serial_host_port_pkg::ST_IDLE) & (mst ? tq_valid : !s_sel_n);
   assign spi_end = (state_r == serial_host_port_pkg::ST_SPI) & rise & (bitc_r == nbits - 5'h1)
                    & (mst | !s_sel_n);
   assign i2c_end = (state_r == serial_host_port_pkg::ST_DATA) & rise & (bitc_r == 5'h7)
                    & (bytec_r == nbytes - 2'h1);
   assign addr_done = (state_r == serial_host_port_pkg::ST_ADDR) & rise & (bitc_r == 5'h7);
   assign ack_exit = (state_r == serial_host_port_pkg::ST_ACK) & ackph_r & fall;
   assign to_data = ack_exit & !nack_r & !(mst & wdone_r);
   // Master read pops and discards its trigger word
   assign pop = tq_valid & (spi_go | spi_end | (to_data & (bytec_r == 2'h0) & (mst | dir_r)));
   assign push = spi_end | (i2c_end & !txb_r); // [R03]
   assign arb_lost = i2c & mst & rise & txb_r & !sda_low_r & !din
                     & ((state_r == serial_host_port_pkg::ST_ADDR)
                        | (state_r == serial_host_port_pkg::ST_DATA));
   // A clean stop follows one data-phase clock rise; later data-phase stops and stops in ACK are errors
   assign err_ev = arb_lost // [R08]
      | (i2c & !mst & stop_det & (((state_r == serial_host_port_pkg::ST_DATA) & (bitc_r > 5'h1))
                                  | (state_r == serial_host_port_pkg::ST_ACK)))
      | (!i2c & !mst & (state_r == serial_host_port_pkg::ST_SPI) & s_sel_n & (bitc_r != 5'h0));

   word_fifo #(.WIDTH(`SHP_WORD_W), .DEPTH(`SHP_TX_DEPTH)) tx_q (
      .ref_clk(ref_clk), .rstn(rstn), .in_valid(tx_valid), .in_ready(tx_ready),
      .in_data(tx_word), .out_valid(tq_valid), .out_ready(pop), .out_data(tq_word));
   word_fifo #(.WIDTH(`SHP_WORD_W), .DEPTH(`SHP_RX_DEPTH)) rx_q ( // [R03]
      .ref_clk(ref_clk), .rstn(rstn), .in_valid(push), .in_ready(rq_ready),
      .in_data(keep(rx_next, nbytes)), .out_valid(rx_valid), .out_ready(rx_ready),
      .out_data(rx_word));

   // Clock generator idles at the bus idle level of the mode
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_r <= `SHP_DIV_RST;
         sck_r <= 1'h0;
      end else if (!run) begin
         div_r <= `SHP_DIV_RST;
         sck_r <= i2c; // [R10]
      end else if (tick) begin
         div_r <= `SHP_DIV_RST;
         if (!((state_r == serial_host_port_pkg::ST_STOP) && sck_r)) begin
            sck_r <= !sck_r; // [R09]
         end
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= serial_host_port_pkg::ST_IDLE;
         sh_r <= `SHP_SH_RST;
         bitc_r <= 5'h00;
         bytec_r <= 2'h0;
         {ackph_r, dir_r, txb_r, sda_low_r, dout_r, last_r, nack_r, wdone_r} <= 8'h00;
      end else if ((i2c & !mst & stop_det) | arb_lost) begin
         state_r <= serial_host_port_pkg::ST_IDLE; // [R11] [R08]
         sda_low_r <= 1'h0;
      end else if (i2c & !mst & start_det) begin
         state_r <= serial_host_port_pkg::ST_ADDR; // [R11]
         {bitc_r, bytec_r, txb_r, sda_low_r} <= 9'h000;
      end else begin
         unique case (state_r)
            serial_host_port_pkg::ST_IDLE: begin
               if (spi_go) begin
                  state_r <= serial_host_port_pkg::ST_SPI;
                  sh_r <= ld; // [R18]
                  dout_r <= ld[23];
                  bitc_r <= 5'h00;
                  last_r <= 1'h0;
               end else if (i2c & mst & tq_valid) begin
                  state_r <= serial_host_port_pkg::ST_START;
                  sda_low_r <= 1'h1; // [R11]
                  sh_r <= {cfg.own_addr, cfg.master_read, 16'h0000};
                  {bitc_r, bytec_r} <= 7'h00;
               end
            end
            serial_host_port_pkg::ST_START: begin
               if (fall) begin
                  state_r <= serial_host_port_pkg::ST_ADDR;
                  sda_low_r <= !sh_r[23];
                  txb_r <= 1'h1;
               end
            end
            serial_host_port_pkg::ST_SPI: begin
               if (!mst & s_sel_n) begin
                  state_r <= serial_host_port_pkg::ST_IDLE; // [R05]
               end else begin
                  if (rise) begin
                     bitc_r <= spi_end ? 5'h00 : bitc_r + 5'h01;
                     sh_r <= spi_end ? ld : rx_next; // [R04] [R18]
                     if (spi_end & mst & !tq_valid) begin
                        last_r <= 1'h1;
                     end
                  end
                  if (fall) begin
                     dout_r <= sh_r[23]; // [R04]
                     if (last_r) begin
                        state_r <= serial_host_port_pkg::ST_IDLE;
                     end
                  end
               end
            end
            serial_host_port_pkg::ST_ADDR, serial_host_port_pkg::ST_DATA: begin
               if (rise) begin
                  sh_r <= rx_next; // [R14]
                  bitc_r <= bitc_r + 5'h01;
                  if (bitc_r == 5'h7) begin
                     bitc_r <= 5'h00;
                     state_r <= serial_host_port_pkg::ST_ACK;
                     {ackph_r, nack_r, wdone_r} <= 3'h0;
                     if (state_r == serial_host_port_pkg::ST_DATA) begin
                        wdone_r <= bytec_r == nbytes - 2'h1;
                        bytec_r <= (bytec_r == nbytes - 2'h1) ? 2'h0 : bytec_r + 2'h1;
                     end else if (!mst) begin
                        dir_r <= addr_byte[0]; // [R13]
                        if (addr_byte[7:1] != cfg.own_addr) begin
                           state_r <= serial_host_port_pkg::ST_IDLE; // [R12]
                        end
                     end
                  end
               end
               if (fall) begin
                  sda_low_r <= txb_r & !sh_r[23];
               end
            end
            serial_host_port_pkg::ST_ACK: begin
               if (fall & !ackph_r) begin
                  ackph_r <= 1'h1;
                  sda_low_r <= !txb_r & !(mst & wdone_r); // [R15]
               end
               if (rise & ackph_r & txb_r) begin
                  nack_r <= din; // [R16]
               end
               if (to_data) begin
                  state_r <= serial_host_port_pkg::ST_DATA;
                  txb_r <= dev_tx;
                  if ((bytec_r == 2'h0) & dev_tx) begin
                     sh_r <= ld;
                     sda_low_r <= !ld[23];
                  end else begin
                     sda_low_r <= dev_tx & !sh_r[23];
                  end
               end else if (ack_exit) begin
                  state_r <= mst ? serial_host_port_pkg::ST_STOP : serial_host_port_pkg::ST_IDLE;
                  sda_low_r <= mst;
               end
            end
            serial_host_port_pkg::ST_STOP: begin
               if (tick & sck_r) begin
                  sda_low_r <= 1'h0; // [R11]
                  state_r <= serial_host_port_pkg::ST_IDLE;
               end
            end
            default: state_r <= serial_host_port_pkg::ST_IDLE;
         endcase
      end
   end

   // Exceptions are one-cycle requests; levels follow FIFO state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= '0;
      end else begin
         irq.rx <= rx_valid; // [R06]
         irq.tx <= tx_ready; // [R06]
         irq.rx_exc <= push & !rq_ready; // [R07]
         irq.bus_err <= err_ev; // [R08]
      end
   end

   assign sck_o = i2c ? 1'h0 : sck_r;
   assign sck_oe = mst & (i2c ? !sck_r : 1'h1); // [R09] [R10]
   assign sda_o = i2c ? 1'h0 : dout_r;
   assign sda_oe = i2c ? sda_low_r
                       : ((state_r == serial_host_port_pkg::ST_SPI) & (mst | !s_sel_n)); // [R05]
   assign sel_out_n = !(mst & !i2c & (state_r == serial_host_port_pkg::ST_SPI));

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_slave_no_clock: assert property (!mst && !$past(mst) // [R10]
      |-> !sck_oe && (sck_r == $past(i2c)))
      else $error("clock driven in slave mode");
   a_div_period: assert property (run && $past(run) && $changed(sck_r)
      |-> $past(div_r) == cfg.clk_div) // [R09]
      else $error("serial clock edge off divider");
   a_spi_deselect: assert property ((state_r == serial_host_port_pkg::ST_SPI) && !i2c && !mst
      && s_sel_n |=> (state_r == serial_host_port_pkg::ST_IDLE) && !sda_oe) // [R05]
      else $error("spi slave active while deselected");
   a_spi_duplex: assert property ((state_r == serial_host_port_pkg::ST_SPI) && rise && !spi_end
      && (mst || !s_sel_n) |=> sh_r == {$past(sh_r[22:0]), $past(din)}) // [R04]
      else $error("spi shift lost");
   a_rx_push: assert property (push && rq_ready |=> rx_valid ##1 irq.rx) // [R03]
      else $error("received word not queued");
   a_rx_overrun: assert property (push && !rq_ready |=> irq.rx_exc) // [R07]
      else $error("overrun not reported");
   a_bus_error: assert property (arb_lost |=> irq.bus_err
      && (state_r == serial_host_port_pkg::ST_IDLE)) // [R08]
      else $error("bus error not reported");
   a_start_seen: assert property (i2c && !mst && start_det
      |=> state_r == serial_host_port_pkg::ST_ADDR) // [R11]
      else $error("start condition missed");
   a_addr_match: assert property (addr_done && !mst && !stop_det && !start_det
      && (addr_byte[7:1] != cfg.own_addr) |=> state_r == serial_host_port_pkg::ST_IDLE) // [R12]
      else $error("foreign address answered");
   a_ack_drive: assert property ((state_r == serial_host_port_pkg::ST_ACK) && fall && !ackph_r
      && !txb_r && !mst && !stop_det && !start_det |=> sda_oe && i2c) // [R15]
      else $error("acknowledge not driven");
   a_ack_sample: assert property ((state_r == serial_host_port_pkg::ST_ACK) && ackph_r && rise
      && txb_r && din && !stop_det && !start_det |=> nack_r) // [R16]
      else $error("acknowledge not sampled");
endmodule : serial_host_port

// ==== tb/spi_far_device.sv ====
/*
 SPI far device: a mode-0 slave that faces the serial host port in master mode.
 Assumes a reply word and bit count set up before each selection.
*/
`timescale 1ns/1ps
module spi_far_device (
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic [23:0] reply,
   input wire logic [5:0] nbits,
   output logic miso,
   output logic [23:0] got
);
   int cnt;
   initial begin
      miso = 1'b0;
      got = 24'h000000;
      cnt = 0;
   end
   always @(negedge sel_n) begin
      got = 24'h000000;
      cnt = 0;
      miso = reply[nbits-1];
   end
   always @(posedge sck) begin
      if (!sel_n) begin
         got = {got[22:0], mosi};
         cnt = cnt + 1;
      end
   end
   always @(negedge sck) begin
      if (!sel_n && cnt < nbits) begin
         miso = reply[nbits-1-cnt];
      end
   end
   // Released line shows no stale bit
   always @(posedge sel_n) begin
      miso = ~miso;
   end
endmodule : spi_far_device

// ==== tb/tb_top.sv ====
/*
 Testbench of the serial host port: SPI master and slave, FIFOs, I2C address.
 Assumes the design's own assertions run beside it; 250 MHz ref_clk.
*/
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rstn, tx_valid, rx_ready, sel_in_n, m_sck, m_sda, m_mosi;
   serial_host_port_pkg::cfg_s cfg;
   serial_host_port_pkg::irq_s irq;
   logic [23:0] tx_word, rx_word, far_reply, far_got;
   logic [5:0] far_bits;
   logic tx_ready, rx_valid, sck_o, sck_oe, sda_o, sda_oe, sel_out_n, far_miso;
   logic sck_i, sda_i, sdi;
   int n_mismatch, comparisons, exc_cnt, err_cnt;
   // Open drain in I2C, push-pull in SPI
   assign sck_i = cfg.i2c_mode ? ((sck_oe && !sck_o) ? 1'b0 : m_sck) : (sck_oe ? sck_o : m_sck);
   assign sda_i = (sda_oe && !sda_o) ? 1'b0 : m_sda;
   assign sdi = cfg.master_select_bit ? far_miso : m_mosi;
   serial_host_port serial_host_port_inst (.ref_clk(ref_clk), .rstn(rstn), .cfg(cfg),
      .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .irq(irq), .sck_i(sck_i), .sck_o(sck_o),
      .sck_oe(sck_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sdi(sdi),
      .sel_in_n(sel_in_n), .sel_out_n(sel_out_n));
   spi_far_device spi_far_device_inst (.sck(sck_i), .sel_n(sel_out_n), .mosi(sda_o),
      .reply(far_reply), .nbits(far_bits), .miso(far_miso), .got(far_got));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (irq.rx_exc === 1'b1) exc_cnt <= exc_cnt + 1;
      if (irq.bus_err === 1'b1) err_cnt <= err_cnt + 1;
   end
   task automatic tally_and_finish;
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic give_up;
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, 24'h0, 24'h1);
      tally_and_finish();
   endtask : give_up
   task automatic wait_level(ref logic s, input logic lvl);
      int i;
      for (i = 0; i < 4000 && s !== lvl; i++) @(negedge ref_clk);
      if (s !== lvl) give_up();
   endtask : wait_level
   task automatic set_cfg(input logic i2c, input logic mst, input logic [1:0] wb);
      @(posedge ref_clk);
      cfg <= '{i2c_mode: i2c, master_select_bit: mst, word_bytes: wb, clk_div: 8'h03,
               own_addr: 7'h2C, master_read: 1'b0};
   endtask : set_cfg
   task automatic push(input logic [23:0] w);
      @(posedge ref_clk);
      tx_word <= w;
      tx_valid <= 1'b1;
      wait_level(tx_ready, 1'b1);
      @(posedge ref_clk);
      tx_valid <= 1'b0;
   endtask : push
   task automatic pop;
      @(posedge ref_clk);
      rx_ready <= 1'b1;
      @(posedge ref_clk);
      rx_ready <= 1'b0;
      @(negedge ref_clk);
   endtask : pop
   // Mode-0 master in place of the far side, high time of 4 cycles, low time of 5 cycles
   task automatic spi_bits(input logic [23:0] mo, input int n, output logic [23:0] mi);
      int i;
      mi = 24'h000000;
      for (i = n - 1; i >= 0; i--) begin
         @(posedge ref_clk) m_mosi <= mo[i];
         repeat (4) @(posedge ref_clk);
         mi = {mi[22:0], sda_o};
         m_sck <= 1'b1;
         repeat (4) @(posedge ref_clk);
         m_sck <= 1'b0;
      end
   endtask : spi_bits
   task automatic spi_master_words;
      logic [23:0] mask;
      int wb;
      for (wb = 1; wb <= 3; wb++) begin
         mask = 24'hFFFFFF >> (24 - 8 * wb);
         set_cfg(1'b0, 1'b1, wb[1:0]);
         far_reply <= 24'h5A1234 & mask;
         far_bits <= 6'(8 * wb);
         push(24'hA5C33C & mask);
         wait_level(sel_out_n, 1'b0);
         chk({23'h0, sck_oe}, 24'h1);
         wait_level(sel_out_n, 1'b1);
         chk(far_got, 24'hA5C33C & mask);
         wait_level(rx_valid, 1'b1);
         chk(rx_word, 24'h5A1234 & mask);
         pop();
      end
   endtask : spi_master_words
   task automatic slave_fill_tx;
      int k;
      set_cfg(1'b0, 1'b0, 2'h1);
      for (k = 0; k < 4; k++) push(24'h0000C1 + k);
      @(negedge ref_clk);
      chk({23'h0, tx_ready}, 24'h0);
      repeat (20) @(posedge ref_clk);
      chk({22'h0, sda_oe, sck_oe}, 24'h0);
      chk({23'h0, irq.tx}, 24'h0);
   endtask : slave_fill_tx
   task automatic slave_overrun;
      logic [23:0] mi;
      int k, e0;
      e0 = exc_cnt;
      @(posedge ref_clk) sel_in_n <= 1'b0;
      for (k = 0; k < 11; k++) begin
         spi_bits(24'h30 + k, 8, mi);
         if (k == 0) chk(mi, 24'h0000C1);
         if (k == 9) begin
            repeat (8) @(posedge ref_clk);
            chk(exc_cnt - e0, 0);
            chk({23'h0, irq.rx}, 24'h1);
         end
      end
      repeat (8) @(posedge ref_clk);
      chk(exc_cnt - e0, 1);
      @(posedge ref_clk) sel_in_n <= 1'b1;
      for (k = 0; k < 10; k++) begin
         chk(rx_word, 24'h30 + k);
         pop();
      end
      chk({23'h0, rx_valid}, 24'h0);
   endtask : slave_overrun
   task automatic slave_abort;
      logic [23:0] mi;
      int e0;
      e0 = err_cnt;
      @(posedge ref_clk) sel_in_n <= 1'b0;
      spi_bits(24'h0F, 4, mi);
      @(posedge ref_clk) sel_in_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(err_cnt - e0, 1);
      chk({23'h0, rx_valid}, 24'h0);
   endtask : slave_abort
   task automatic i2c_addr(input logic [7:0] b, input logic exp_ack);
      int i;
      int e0;
      e0 = err_cnt;
      set_cfg(1'b1, 1'b0, 2'h1);
      repeat (20) @(posedge ref_clk);
      m_sda <= 1'b0;
      repeat (8) @(posedge ref_clk);
      m_sck <= 1'b0;
      for (i = 7; i >= 0; i--) begin
         m_sda <= b[i];
         repeat (8) @(posedge ref_clk);
         m_sck <= 1'b1;
         repeat (8) @(posedge ref_clk);
         m_sck <= 1'b0;
      end
      m_sda <= 1'b1;
      repeat (8) @(posedge ref_clk);
      m_sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({23'h0, sda_i}, {23'h0, !exp_ack});
      repeat (4) @(posedge ref_clk);
      m_sck <= 1'b0;
      repeat (8) @(posedge ref_clk);
      m_sda <= 1'b0;
      repeat (8) @(posedge ref_clk);
      m_sck <= 1'b1;
      repeat (8) @(posedge ref_clk);
      m_sda <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(24'(err_cnt - e0), 24'h000000);
   endtask : i2c_addr
   // Master with nobody answering: start, address out, acknowledge read as high
   task automatic i2c_master_nack;
      logic [8:0] seen;
      int i;
      seen = 9'h000;
      set_cfg(1'b1, 1'b1, 2'h1);
      push(24'h0000AA);
      wait_level(sda_i, 1'b0);
      chk({23'h0, sck_i}, 24'h000001);
      for (i = 8; i >= 0; i--) begin
         wait_level(sck_i, 1'b0);
         wait_level(sck_i, 1'b1);
         seen[i] = sda_i;
      end
      chk({15'h0, seen}, 24'h0000B1);
   endtask : i2c_master_nack
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      exc_cnt = 0;
      err_cnt = 0;
      rstn = 1'b0;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      tx_word = 24'h000000;
      sel_in_n = 1'b1;
      m_sck = 1'b0;
      m_sda = 1'b1;
      m_mosi = 1'b0;
      far_reply = 24'h000000;
      far_bits = 6'h08;
      cfg = '{i2c_mode: 1'b0, master_select_bit: 1'b0, word_bytes: 2'h1, clk_div: 8'h03,
              own_addr: 7'h2C, master_read: 1'b0};
      repeat (16) @(posedge ref_clk);
      chk({20'h0, tx_ready, rx_valid, sel_out_n, sda_oe}, 24'h0000A);
      chk({20'h0, irq}, 24'h0);
      @(posedge ref_clk) rstn <= 1'b1;
      spi_master_words();
      slave_fill_tx();
      slave_overrun();
      slave_abort();
      m_sck <= 1'b1;
      i2c_addr(8'h58, 1'b1);
      i2c_addr(8'h5A, 1'b0);
      i2c_master_nack();
      tally_and_finish();
   end
endmodule : tb_top
